// ### core/dma_transfer_step_wrap_ctrl.sv
// Burst-level transfer counting, pointer stepping and wrap control of one DMA channel
//
// What this block does
// - A 16-bit bursts-left counter holds how many bursts remain after the current one, at most 65535.
// - Reading the bursts-left counter gives its value as it stood when the channel halted.
// - After each burst other than the last or a wrapping one, the signed 16-bit source step is added to the source pointer.
// - After each burst other than the last or a wrapping one, the signed 16-bit destination step is added to the destination pointer.
// - Step code 0x0FFF adds 4095 and code 0xF000 subtracts 4096.
// - Pointers wrap to the begin address after wrap length plus one bursts.
// - A wrap length larger than the transfer length disables wrapping for that transfer.
// - A transfer length of N asks for N plus one bursts.
// - A 16-bit wrap counter holds the bursts left before the next wrap, zero meaning due.
// - When the wrap counter expires the signed wrap step is added to the begin pointers.
`timescale 1ns/10ps
`default_nettype none
`include "step_wrap_map.svh"

module dma_transfer_step_wrap_ctrl #(
    parameter int unsigned ADDR_W = 22
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [ADDR_W-1:0] src_begin_i,
    input  wire logic [ADDR_W-1:0] dst_begin_i,
    input  wire logic              burst_done_valid_i,
    output logic                   burst_done_ready_o,
    output logic                   next_valid_o,
    input  wire logic              next_ready_i,
    output logic      [ADDR_W-1:0] next_src_o,
    output logic      [ADDR_W-1:0] next_dst_o,
    output logic                   busy_o
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Sign extension is exact for the whole 16-bit step range -32768..32767
    function automatic logic [ADDR_W-1:0] add_step(
        input logic [ADDR_W-1:0] a,
        input logic [15:0]       s
    );
        add_step = a + {{(ADDR_W-16){s[15]}}, s};
    endfunction

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    logic        ack_q;
    logic        ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic        wr_commit;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_len;
    logic        wr_count;
    logic        wr_sstep;
    logic        wr_dstep;
    logic        wr_wlen;
    logic        wr_wleft;
    logic        wr_bstep;

    step_wrap_pkg::ctrl_state_t state_q;
    step_wrap_pkg::ctrl_state_t state_d;
    logic                   pend_q;
    logic                   pend_d;
    logic                   done_q;
    logic                   done_d;
    logic                   wrap_en_q;
    logic                   wrap_en_d;
    step_wrap_pkg::field16_t xfer_len_q;
    step_wrap_pkg::field16_t xfer_len_d;
    step_wrap_pkg::field16_t count_q;
    step_wrap_pkg::field16_t count_d;
    step_wrap_pkg::field16_t src_step_q;
    step_wrap_pkg::field16_t src_step_d;
    step_wrap_pkg::field16_t dst_step_q;
    step_wrap_pkg::field16_t dst_step_d;
    step_wrap_pkg::field16_t wrap_len_q;
    step_wrap_pkg::field16_t wrap_len_d;
    step_wrap_pkg::field16_t wrap_left_q;
    step_wrap_pkg::field16_t wrap_left_d;
    step_wrap_pkg::field16_t wstep_q;
    step_wrap_pkg::field16_t wstep_d;
    logic [ADDR_W-1:0]      src_beg_q;
    logic [ADDR_W-1:0]      src_beg_d;
    logic [ADDR_W-1:0]      dst_beg_q;
    logic [ADDR_W-1:0]      dst_beg_d;
    logic [ADDR_W-1:0]      src_cur_q;
    logic [ADDR_W-1:0]      src_cur_d;
    logic [ADDR_W-1:0]      dst_cur_q;
    logic [ADDR_W-1:0]      dst_cur_d;
    logic                   take;
    logic                   wrap_fire;
    logic                   push;
    logic                   buf_in_ready;

    assign ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
    // Write lands on the edge where the master sees ack
    assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign wr_ctrl   = wr_commit && hit(wb_adr_i, `OFF_CTRL);
    assign wr_stat   = wr_commit && hit(wb_adr_i, `OFF_STATUS);
    assign wr_len    = wr_commit && hit(wb_adr_i, `OFF_XFER_LEN);
    assign wr_count  = wr_commit && hit(wb_adr_i, `OFF_BURSTS_LEFT);
    assign wr_sstep  = wr_commit && hit(wb_adr_i, `OFF_SRC_STEP);
    assign wr_dstep  = wr_commit && hit(wb_adr_i, `OFF_DST_STEP);
    assign wr_wlen   = wr_commit && hit(wb_adr_i, `OFF_WRAP_LEN);
    assign wr_wleft  = wr_commit && hit(wb_adr_i, `OFF_WRAP_LEFT);
    assign wr_bstep  = wr_commit && hit(wb_adr_i, `OFF_BEGIN_STEP);

    // Counters move only on a start, a burst end or a register write, so a read while halted is the halt value
    always_comb begin
        dat_d = dat_q;
        if (ack_d) begin
            dat_d = 32'h00000000;
            unique case ({2'b00, wb_adr_i[7:2]})
                `OFF_STATUS >> 2:      dat_d = {30'h00000000, done_q, state_q == step_wrap_pkg::ST_RUN};
                `OFF_XFER_LEN >> 2:    dat_d = {16'h0000, xfer_len_q};
                `OFF_BURSTS_LEFT >> 2: dat_d = {16'h0000, count_q};
                `OFF_SRC_STEP >> 2:    dat_d = {16'h0000, src_step_q};
                `OFF_DST_STEP >> 2:    dat_d = {16'h0000, dst_step_q};
                `OFF_WRAP_LEN >> 2:    dat_d = {16'h0000, wrap_len_q};
                `OFF_WRAP_LEFT >> 2:   dat_d = {16'h0000, wrap_left_q};
                `OFF_BEGIN_STEP >> 2:  dat_d = {16'h0000, wstep_q};
                default:               dat_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ---------------------------------------------------------------
    // Transfer sequencing
    // ---------------------------------------------------------------
    assign take = (state_q == step_wrap_pkg::ST_RUN) && burst_done_valid_i && buf_in_ready;

    always_comb begin
        state_d     = state_q;
        pend_d      = pend_q;
        done_d      = done_q;
        wrap_en_d   = wrap_en_q;
        xfer_len_d  = wr_len ? merge16(xfer_len_q, wb_dat_i, wb_sel_i) : xfer_len_q;
        count_d     = wr_count ? merge16(count_q, wb_dat_i, wb_sel_i) : count_q;
        src_step_d  = wr_sstep ? merge16(src_step_q, wb_dat_i, wb_sel_i) : src_step_q;
        dst_step_d  = wr_dstep ? merge16(dst_step_q, wb_dat_i, wb_sel_i) : dst_step_q;
        wrap_len_d  = wr_wlen ? merge16(wrap_len_q, wb_dat_i, wb_sel_i) : wrap_len_q;
        wrap_left_d = wr_wleft ? merge16(wrap_left_q, wb_dat_i, wb_sel_i) : wrap_left_q;
        wstep_d     = wr_bstep ? merge16(wstep_q, wb_dat_i, wb_sel_i) : wstep_q;
        src_beg_d   = src_beg_q;
        dst_beg_d   = dst_beg_q;
        src_cur_d   = src_cur_q;
        dst_cur_d   = dst_cur_q;
        push        = 1'b0;
        wrap_fire   = 1'b0;
        if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`CTRL_START_BIT]) begin
            pend_d = 1'b1;
        end
        if (wr_stat && wb_sel_i[0] && wb_dat_i[`STAT_DONE_BIT]) begin
            done_d = 1'b0;
        end
        unique case (state_q)
            step_wrap_pkg::ST_IDLE: begin
                // Start waits for buffer room so the first pointer pair is never lost
                if (pend_q && buf_in_ready) begin
                    state_d     = step_wrap_pkg::ST_RUN;
                    pend_d      = 1'b0;
                    count_d     = xfer_len_q;
                    wrap_left_d = wrap_len_q;
                    wrap_en_d   = (wrap_len_q <= xfer_len_q);
                    src_beg_d   = src_begin_i;
                    dst_beg_d   = dst_begin_i;
                    src_cur_d   = src_begin_i;
                    dst_cur_d   = dst_begin_i;
                    push        = 1'b1;
                end
            end
            step_wrap_pkg::ST_RUN: begin
                if (take) begin
                    if (count_q == 16'h0000) begin
                        state_d = step_wrap_pkg::ST_IDLE;
                        done_d  = 1'b1;
                    end else begin
                        count_d = count_q - 16'h0001;
                        if (wrap_en_q && (wrap_left_q == 16'h0000)) begin
                            wrap_fire   = 1'b1;
                            src_beg_d   = add_step(src_beg_q, wstep_q);
                            dst_beg_d   = add_step(dst_beg_q, wstep_q);
                            src_cur_d   = src_beg_d;
                            dst_cur_d   = dst_beg_d;
                            wrap_left_d = wrap_len_q;
                        end else begin
                            src_cur_d = add_step(src_cur_q, src_step_q);
                            dst_cur_d = add_step(dst_cur_q, dst_step_q);
                            if (wrap_left_q != 16'h0000) begin
                                wrap_left_d = wrap_left_q - 16'h0001;
                            end
                        end
                        push = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= step_wrap_pkg::ST_IDLE;
            pend_q      <= 1'b0;
            done_q      <= 1'b0;
            wrap_en_q   <= 1'b0;
            xfer_len_q  <= `RST_FIELD16;
            count_q     <= `RST_FIELD16;
            src_step_q  <= `RST_FIELD16;
            dst_step_q  <= `RST_FIELD16;
            wrap_len_q  <= `RST_FIELD16;
            wrap_left_q <= `RST_FIELD16;
            wstep_q     <= `RST_FIELD16;
            src_beg_q   <= '0;
            dst_beg_q   <= '0;
            src_cur_q   <= '0;
            dst_cur_q   <= '0;
        end else begin
            state_q     <= state_d;
            pend_q      <= pend_d;
            done_q      <= done_d;
            wrap_en_q   <= wrap_en_d;
            xfer_len_q  <= xfer_len_d;
            count_q     <= count_d;
            src_step_q  <= src_step_d;
            dst_step_q  <= dst_step_d;
            wrap_len_q  <= wrap_len_d;
            wrap_left_q <= wrap_left_d;
            wstep_q     <= wstep_d;
            src_beg_q   <= src_beg_d;
            dst_beg_q   <= dst_beg_d;
            src_cur_q   <= src_cur_d;
            dst_cur_q   <= dst_cur_d;
        end
    end

    assign busy_o             = (state_q == step_wrap_pkg::ST_RUN);
    assign burst_done_ready_o = busy_o && buf_in_ready;

    // ---------------------------------------------------------------
    // Next pointer buffer
    // ---------------------------------------------------------------
    // Two entries let the pair be pushed while the previous one waits
    pair_buffer #(
        .WIDTH (2 * ADDR_W),
        .DEPTH (2)
    ) u_next_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({src_cur_d, dst_cur_d}),
        .out_valid_o (next_valid_o),
        .out_ready_i (next_ready_i),
        .out_data_o  ({next_src_o, next_dst_o})
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_count_load_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == step_wrap_pkg::ST_IDLE && pend_q && buf_in_ready)
        |=> (count_q == $past(xfer_len_q)) && (wrap_left_q == $past(wrap_len_q)) && busy_o)
        else $error("counters not loaded at start");

    a_count_decrement: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && count_q != 16'h0000) |=> (count_q == $past(count_q) - 16'h0001))
        else $error("bursts left did not count down");

    a_final_burst_end: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && count_q == 16'h0000) |-> !push ##1 (!busy_o && done_q))
        else $error("transfer did not end on last burst");

    a_src_step_add: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && count_q != 16'h0000 && !wrap_fire)
        |=> (src_cur_q == add_step($past(src_cur_q), $past(src_step_q))))
        else $error("source pointer not stepped");

    a_dst_step_add: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && count_q != 16'h0000 && !wrap_fire)
        |=> (dst_cur_q == add_step($past(dst_cur_q), $past(dst_step_q))))
        else $error("destination pointer not stepped");

    a_step_most_negative: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && count_q != 16'h0000 && !wrap_fire && src_step_q == 16'hF000)
        |=> (src_cur_q == $past(src_cur_q) - 22'h001000))
        else $error("step code F000 did not subtract 4096");

    a_wrap_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap_fire |=> (src_cur_q == src_beg_q) && (dst_cur_q == dst_beg_q)
                      && (wrap_left_q == $past(wrap_len_q)))
        else $error("wrap did not reload pointers and counter");

    a_begin_step_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap_fire |=> (src_beg_q == add_step($past(src_beg_q), $past(wstep_q))))
        else $error("begin pointer not stepped on wrap");

    a_wrap_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == step_wrap_pkg::ST_IDLE && pend_q && buf_in_ready && (wrap_len_q > xfer_len_q))
        |=> !wrap_en_q)
        else $error("wrap enabled although wrap length exceeds transfer length");

    a_wrap_due_only: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap_fire |-> (wrap_left_q == 16'h0000) && wrap_en_q && $past(busy_o))
        else $error("wrap fired before counter expired");

    a_idle_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && !pend_q && !wr_count) |=> $stable(count_q))
        else $error("halted count changed");

endmodule

`default_nettype wire

// ### core/pair_buffer.sv
// Small valid/ready buffer for the next pointer pair
`timescale 1ns/10ps
`default_nettype none

module pair_buffer #(
    parameter int unsigned WIDTH = 44,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    wr_d;
    logic [PW-1:0]    rd_q;
    logic [PW-1:0]    rd_d;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready_o  = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data_i;
            wr_d        = bump(wr_q);
        end
        if (pop) begin
            rd_d = bump(rd_q);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Data storage needs no reset, count guards it
    always_ff @(posedge clk_i) begin
        mem_q <= mem_d;
    end

    a_buffer_fill_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (push && !pop) |=> (cnt_q == $past(cnt_q) + CW'(1)))
        else $error("buffer count did not rise on push");

endmodule

`default_nettype wire

// ### core/step_wrap_map.svh
// Register offsets, field positions and reset values of the step/wrap controller
`ifndef STEP_WRAP_MAP_SVH
`define STEP_WRAP_MAP_SVH

`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_XFER_LEN    8'h08
`define OFF_BURSTS_LEFT 8'h0C
`define OFF_SRC_STEP    8'h10
`define OFF_DST_STEP    8'h14
`define OFF_WRAP_LEN    8'h18
`define OFF_WRAP_LEFT   8'h1C
`define OFF_BEGIN_STEP  8'h20

`define CTRL_START_BIT  0
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1

`define RST_FIELD16     16'h0000

`endif

// ### core/step_wrap_pkg.sv
// Types shared by the step/wrap controller
`default_nettype none

package step_wrap_pkg;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } ctrl_state_t;

    typedef logic [15:0] field16_t;

endpackage

`default_nettype wire

// ### tb/burst_side_model.sv
// Far-side model: takes pointer pairs and reports one finished burst per pair
`timescale 1ns/10ps
`default_nettype none

module burst_side_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        stall_i,
    input  wire logic        next_valid_i,
    output logic             next_ready_o,
    input  wire logic        burst_done_ready_i,
    output logic             burst_done_valid_o
);
    logic has_q;

    // ----------------------------------------
    // One burst in flight at a time
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            has_q              <= 1'b0;
            next_ready_o       <= 1'b0;
            burst_done_valid_o <= 1'b0;
        end else begin
            if (next_valid_i && next_ready_o) begin
                has_q        <= 1'b1;
                next_ready_o <= 1'b0;
            end else if (!has_q) begin
                next_ready_o <= !stall_i;
            end
            // Held until taken, a stall never drops it
            if (burst_done_valid_o && burst_done_ready_i) begin
                burst_done_valid_o <= 1'b0;
                has_q              <= 1'b0;
            end else if (has_q && !burst_done_valid_o && !stall_i) begin
                burst_done_valid_o <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/dma_transfer_step_wrap_ctrl_tb.sv
// Self-checking bench of the step/wrap controller
`timescale 1ns/10ps
`default_nettype none

module dma_transfer_step_wrap_ctrl_tb;
    logic        clk_i, rst_i, cyc, stb, we, stall, bd_valid, bd_ready;
    logic        nx_valid, nx_ready, busy;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q, seed;
    logic        ack;
    logic [21:0] sbeg, dbeg, nsrc, ndst;
    logic [43:0] exp_q[$];
    logic [15:0] exp_wleft;
    int          fail_count, num_checks;

    dma_transfer_step_wrap_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .src_begin_i(sbeg), .dst_begin_i(dbeg),
        .burst_done_valid_i(bd_valid), .burst_done_ready_o(bd_ready),
        .next_valid_o(nx_valid), .next_ready_i(nx_ready), .next_src_o(nsrc),
        .next_dst_o(ndst), .busy_o(busy));
    burst_side_model far (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
        .next_valid_i(nx_valid), .next_ready_o(nx_ready),
        .burst_done_ready_i(bd_ready), .burst_done_valid_o(bd_valid));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [21:0] step_add(input logic [21:0] a, input logic [15:0] s);
        return a + {{6{s[15]}}, s};
    endfunction
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) check("bus ack", 0, 1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    // Every pair handed out must match the reference sequence
    always @(posedge clk_i) begin
        stall <= xs() % 3 == 0;
        if (nx_valid === 1'b1 && nx_ready === 1'b1) begin
            if (exp_q.size() == 0) check("extra pair", 1, 0);
            else check("pointer pair", {nsrc, ndst}, exp_q.pop_front());
        end
    end

    // Reference: begin pair, then one pair per burst except the last
    task automatic run_xfer(input logic [15:0] len, wl, ss, ds, ws);
        logic [21:0] cs, cd, bs, bd;
        int n;
        bs = 22'(xs());
        bd = 22'(xs());
        @(posedge clk_i);
        sbeg <= bs;
        dbeg <= bd;
        cs = bs;
        cd = bd;
        exp_wleft = wl;
        exp_q.push_back({cs, cd});
        for (int k = 0; k < int'(len); k++) begin
            if (wl <= len && exp_wleft == 16'h0000) begin
                bs = step_add(bs, ws);
                bd = step_add(bd, ws);
                cs = bs;
                cd = bd;
                exp_wleft = wl;
            end else begin
                cs = step_add(cs, ss);
                cd = step_add(cd, ds);
                if (exp_wleft != 16'h0000) exp_wleft = exp_wleft - 16'h0001;
            end
            exp_q.push_back({cs, cd});
        end
        wb(1, 8'h08, {16'h0000, len});
        wb(1, 8'h10, {16'h0000, ss});
        wb(1, 8'h14, {16'h0000, ds});
        wb(1, 8'h18, {16'h0000, wl});
        wb(1, 8'h20, {16'h0000, ws});
        wb(1, 8'h00, 32'h0000_0001);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b1 && n < 20);
        if (n >= 20) check("transfer start", 0, 1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 4000);
        if (n >= 4000) check("transfer end", 0, 1);
        check("pairs left", exp_q.size(), 0);
        wb(0, 8'h0C, 0);
        check("bursts left", q, 0);
        wb(0, 8'h1C, 0);
        check("wrap left", q, {16'h0000, exp_wleft});
        wb(0, 8'h04, 0);
        check("status", q, 32'h0000_0002);
        wb(1, 8'h04, 32'h0000_0002);
        wb(0, 8'h04, 0);
        check("status cleared", q, 32'h0000_0000);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        #(50 * 60000);
        fail_count++;
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] st[6];
        logic [15:0] r;
        seed = 32'h9D76_8862; fail_count = 0; num_checks = 0;
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        wdat = 32'h0; sbeg = 22'h0; dbeg = 22'h0; stall = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 8; a <= 32; a += 4) begin
            wb(0, 8'(a), 0);
            check("reset value", q, 0);
        end
        wb(1, 8'h40, 32'h0000_FFFF);
        wb(0, 8'h40, 0);
        check("unmapped", q, 0);
        for (int a = 8; a <= 32; a += 4) begin
            r = 16'(xs());
            wb(1, 8'(a), {16'hFFFF, r});
            wb(0, 8'(a), 0);
            check("readback", q, {16'h0000, r});
        end
        st = '{16'h0FFF, 16'hF000, 16'hFFFF, 16'hFFFE, 16'h0000, 16'h0002};
        // Source gets the most negative step so its check is reached
        run_xfer(16'h0003, 16'hFFFF, st[1], st[0], 16'h0000);
        run_xfer(16'h0004, 16'h0005, st[2], st[3], st[0]);
        run_xfer(16'h0006, 16'h0001, st[5], st[4], st[1]);
        run_xfer(16'h0000, 16'h0000, st[0], st[0], st[0]);
        for (int i = 0; i < 8; i++) begin
            // Steps stay within -4096..4095
            run_xfer(xs() % 9, xs() % 10, 16'(signed'(xs() % 8192) - 4096),
                     16'(signed'(xs() % 8192) - 4096), 16'(signed'(xs() % 8192) - 4096));
        end
        final_report();
    end
endmodule

`default_nettype wire
